// file: rtl/ltdt_pkg.sv
// Constants shared by the bus transmit-control block
// Summary of operation
// - Low transmit input drives bus dominant
// - High or open input leaves bus recessive
// - Long dominant input forces driver recessive
// - Release time high clears time-out, re-enables
// - Disable setting lets long dominant pass
// - High-speed bit bypasses edge slope control
// - Pull-up only in active mode, transceiver enabled
// - Supply undervoltage suppresses transmission and switches
// - Power-up enters active, watchdog per divider pin
// - Regulator undervoltage asserts active-low reset output
// - Receive output mirrors bus, high when disabled
package ltdt_pkg;
  localparam int unsigned CLK_HZ                = 40_000_000;
  // Dominant time-out, microseconds
  localparam int unsigned DOMINANT_TIMEOUT_US   = 6_000;
  // Release time, microseconds
  localparam int unsigned TIMEOUT_RELEASE_US    = 10;
  // Regulator reset hold time, microseconds
  localparam int unsigned RESET_HOLD_US         = 4_000;
  localparam int unsigned DOM_CYCLES  = (DOMINANT_TIMEOUT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned REL_CYCLES  = (TIMEOUT_RELEASE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned HOLD_CYCLES = (RESET_HOLD_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BUF_DEPTH   = 2;
  localparam logic        RECESSIVE   = 1'b1;
  localparam logic        DOMINANT    = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_DRIVE   = 3'b010,
    ST_TIMEOUT = 3'b100
  } ltdt_state_type;
endpackage

// file: rtl/ltdt_buf.sv
// Two-entry valid/ready buffer for transmit bit samples
`timescale 1ns/1ps
`default_nettype none
module ltdt_buf
  import ltdt_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] mem_q [BUF_DEPTH];
  logic             wr_q;
  logic             rd_q;
  logic [1:0]       cnt_q;
  logic             push;
  logic             pop;

  // Handshakes on each side
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_q != 2'(BUF_DEPTH));
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];

  // Storage and pointers; stall on full keeps words
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= '1;
      mem_q[1] <= '1;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule
`default_nettype wire

// file: rtl/ltdt_ctrl.sv
// Transmit-side dominant time-out control of a single-wire bus transceiver
`timescale 1ns/1ps
`default_nettype none
module ltdt_ctrl
  import ltdt_pkg::*;
#(
  parameter int unsigned DOM_CNT  = DOM_CYCLES,
  parameter int unsigned REL_CNT  = REL_CYCLES,
  parameter int unsigned HOLD_CNT = HOLD_CYCLES
) (
  input  wire logic REF_CLK,
  input  wire logic RST,
  input  wire logic TX_DATA,
  input  wire logic TX_DATA_CONNECTED,
  input  wire logic BUS_LEVEL,
  input  wire logic TRANSCEIVER_ENABLE,
  input  wire logic TIMEOUT_DISABLE,
  input  wire logic HIGH_SPEED_SLOPE_BYPASS,
  input  wire logic SUPPLY_UNDERVOLTAGE,
  input  wire logic REGULATOR_UNDERVOLTAGE,
  input  wire logic DIVIDER_PIN,
  input  wire logic RX_READY,
  output logic      BUS_DRIVE_LOW,
  output logic      PULLUP_ON,
  output logic      SLOPE_CONTROL_ON,
  output logic      RX_DATA,
  output logic      RESET_OUT_LOW,
  output logic      RESET_OUT_LOW_OE,
  output logic      ACTIVE_MODE,
  output logic      WATCHDOG_ON,
  output logic      SWITCH_OUT_ENABLE,
  output logic      TX_STALL
);
  localparam int DW = $clog2(DOM_CNT + 1);
  localparam int RW = $clog2(REL_CNT + 1);
  localparam int HW = $clog2(HOLD_CNT + 1);
  // Last count at which the driver may still pull; the next edge releases it
  localparam int unsigned DOM_LAST = DOM_CNT - 1;

  ltdt_state_type state_q;
  ltdt_state_type state_d;
  logic [DW-1:0]  dom_q;
  logic [RW-1:0]  rel_q;
  logic [HW-1:0]  hold_q;
  logic           tx_s1_q;
  logic           tx_s2_q;
  logic           active_q;
  logic           tx_eff;
  logic           buf_in_ready;
  logic           buf_out_valid;
  logic           buf_out_data;
  logic           tx_bit;
  logic           allowed;

  // Level decode shared by the state machine and both counters
  function automatic logic is_dominant(input logic lvl);
    return (lvl == DOMINANT);
  endfunction

  // Open input reads high, like an internal pull-up
  assign tx_eff = TX_DATA_CONNECTED ? TX_DATA : RECESSIVE;

  // Two-stage synchroniser into the internal timebase
  // Only the second stage is read, so a metastable first stage stays local
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tx_s1_q <= RECESSIVE;
      tx_s2_q <= RECESSIVE;
    end else begin
      tx_s1_q <= tx_eff;
      tx_s2_q <= tx_s1_q;
    end
  end

  // Sample buffer; the driver side drains only while RX_READY is high, otherwise the input stalls
  ltdt_buf #(
    .WIDTH (1)
  ) u_buf (
    .clk       (REF_CLK),
    .rst       (RST),
    .in_valid  (1'b1),
    .in_ready  (buf_in_ready),
    .in_data   (tx_s2_q),
    .out_valid (buf_out_valid),
    .out_ready (RX_READY),
    .out_data  (buf_out_data)
  );

  // An empty buffer is treated as recessive, the safe level
  assign tx_bit  = buf_out_valid ? buf_out_data : RECESSIVE;
  assign allowed = active_q && TRANSCEIVER_ENABLE && !SUPPLY_UNDERVOLTAGE;

  // Time-out state machine; a time-out is left only through a full
  // release, so a short high glitch cannot re-arm the driver
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (is_dominant(tx_bit)) begin
          state_d = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (!is_dominant(tx_bit)) begin
          state_d = ST_IDLE;
        end else if (!TIMEOUT_DISABLE && (dom_q >= DW'(DOM_LAST))) begin
          state_d = ST_TIMEOUT;
        end
      end
      ST_TIMEOUT: begin
        if (rel_q >= RW'(REL_CNT)) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Dominant period counter, saturating
  // Saturation keeps a disabled time-out from wrapping and firing late
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      dom_q <= '0;
    end else if (state_q != ST_DRIVE || !is_dominant(tx_bit)) begin
      dom_q <= '0;
    end else if (dom_q < DW'(DOM_CNT)) begin
      dom_q <= DW'(dom_q + 1'b1);
    end
  end

  // Release counter; any low input restarts the wait
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rel_q <= '0;
    end else if (state_q != ST_TIMEOUT || is_dominant(tx_bit)) begin
      rel_q <= '0;
    end else if (rel_q < RW'(REL_CNT)) begin
      rel_q <= RW'(rel_q + 1'b1);
    end
  end

  // Bus driver and pull-up; time-out wins over the input
  // Driver follows the next state so release costs no extra cycle
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      BUS_DRIVE_LOW <= 1'b0;
      PULLUP_ON     <= 1'b0;
    end else begin
      BUS_DRIVE_LOW <= allowed && (state_d == ST_DRIVE);
      PULLUP_ON     <= active_q && TRANSCEIVER_ENABLE;
    end
  end

  // Slope control and receive path
  // Receive output parks high while disabled, never a false dominant
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      SLOPE_CONTROL_ON <= 1'b1;
      RX_DATA          <= RECESSIVE;
      TX_STALL         <= 1'b0;
    end else begin
      SLOPE_CONTROL_ON <= !HIGH_SPEED_SLOPE_BYPASS;
      RX_DATA          <= TRANSCEIVER_ENABLE ? BUS_LEVEL : RECESSIVE;
      TX_STALL         <= !buf_in_ready;
    end
  end

  // Regulator undervoltage reset with hold time after recovery
  // Any dip restarts the hold, so a bouncing regulator keeps reset low
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      hold_q <= '0;
    end else if (REGULATOR_UNDERVOLTAGE) begin
      hold_q <= '0;
    end else if (hold_q < HW'(HOLD_CNT)) begin
      hold_q <= HW'(hold_q + 1'b1);
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RESET_OUT_LOW    <= 1'b0;
      RESET_OUT_LOW_OE <= 1'b1;
    end else begin
      RESET_OUT_LOW    <= 1'b0;
      RESET_OUT_LOW_OE <= REGULATOR_UNDERVOLTAGE || (hold_q < HW'(HOLD_CNT));
    end
  end

  // Power-up: active mode; divider pin strap followed while reset is low
  // The last value seen before the reset pin releases is the one kept
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      active_q    <= 1'b0;
      WATCHDOG_ON <= 1'b0;
    end else begin
      active_q <= 1'b1;
      if (RESET_OUT_LOW_OE) begin
        WATCHDOG_ON <= !DIVIDER_PIN;
      end
    end
  end

  // Mode and switch-interface outputs
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ACTIVE_MODE       <= 1'b0;
      SWITCH_OUT_ENABLE <= 1'b0;
    end else begin
      ACTIVE_MODE       <= active_q;
      SWITCH_OUT_ENABLE <= active_q && !SUPPLY_UNDERVOLTAGE;
    end
  end
endmodule
`default_nettype wire

// file: test/ltdt_ctrl_props.sv
// Port-level assertions for the transmit-control block
`timescale 1ns/1ps
`default_nettype none
module ltdt_ctrl_props #(
  parameter int unsigned DOM_CNT = 50
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic TX_DATA,
  input wire logic TX_DATA_CONNECTED,
  input wire logic BUS_LEVEL,
  input wire logic TRANSCEIVER_ENABLE,
  input wire logic TIMEOUT_DISABLE,
  input wire logic HIGH_SPEED_SLOPE_BYPASS,
  input wire logic SUPPLY_UNDERVOLTAGE,
  input wire logic REGULATOR_UNDERVOLTAGE,
  input wire logic RX_READY,
  input wire logic BUS_DRIVE_LOW,
  input wire logic PULLUP_ON,
  input wire logic SLOPE_CONTROL_ON,
  input wire logic RX_DATA,
  input wire logic RESET_OUT_LOW_OE,
  input wire logic SWITCH_OUT_ENABLE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  int unsigned run_q;
  // Length of a driven stretch while the time-out is armed
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) run_q <= 0;
    else if (BUS_DRIVE_LOW && !TIMEOUT_DISABLE) run_q <= run_q + 1;
    else run_q <= 0;
  end
  a_drive_dom: assert property ((!TX_DATA && TX_DATA_CONNECTED && TRANSCEIVER_ENABLE &&
    !SUPPLY_UNDERVOLTAGE && TIMEOUT_DISABLE && RX_READY)[*5] |-> BUS_DRIVE_LOW)
    else $error("bus not driven on held low input");
  a_tx_rec: assert property (((TX_DATA || !TX_DATA_CONNECTED) && RX_READY)[*5]
    |-> !BUS_DRIVE_LOW) else $error("bus driven on high input");
  a_dom_limit: assert property (run_q <= DOM_CNT)
    else $error("driver outlived the time-out");
  a_slope_bypass: assert property ($stable(HIGH_SPEED_SLOPE_BYPASS)
    |-> SLOPE_CONTROL_ON != HIGH_SPEED_SLOPE_BYPASS) else $error("slope control wrong");
  a_pullup_gate: assert property (!TRANSCEIVER_ENABLE |=> !PULLUP_ON)
    else $error("pull-up on while disabled");
  a_uv_quiet: assert property (SUPPLY_UNDERVOLTAGE[*2]
    |-> !BUS_DRIVE_LOW && !SWITCH_OUT_ENABLE) else $error("output under low supply");
  a_rx_idle: assert property (!TRANSCEIVER_ENABLE |=> RX_DATA)
    else $error("receive output low while disabled");
  a_rx_mirror: assert property (TRANSCEIVER_ENABLE[*2] |-> RX_DATA == $past(BUS_LEVEL))
    else $error("receive output misses bus level");
  a_reset_uv: assert property (REGULATOR_UNDERVOLTAGE |=> RESET_OUT_LOW_OE)
    else $error("reset not asserted on low regulator");
endmodule
`default_nettype wire

// file: test/ltdt_host.sv
// Host model driving the transmit-data input
`timescale 1ns/1ps
`default_nettype none
module ltdt_host (
  input  wire logic clk,
  output var logic  tx,
  output var logic  con
);
  // Hold a level n edges; an open input shows the raw wire level,
  // so only the device's own pull-up can make it read high
  task automatic hold(input logic lvl, input logic open, input int n);
    @(posedge clk);
    tx  <= lvl;
    con <= !open;
    repeat (n - 1) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// file: test/ltdt_ctrl_tb_top.sv
// Self-checking bench for the transmit-control block
`timescale 1ns/1ps
`default_nettype none
module ltdt_ctrl_tb_top;
  import ltdt_pkg::*;
  localparam int unsigned DOM = 50;
  localparam int unsigned REL = 5;
  localparam int unsigned HOLD = 20;
  logic REF_CLK, RST, TX_DATA, TX_DATA_CONNECTED, BUS_LEVEL, TRANSCEIVER_ENABLE, bus_low;
  logic TIMEOUT_DISABLE, HIGH_SPEED_SLOPE_BYPASS, SUPPLY_UNDERVOLTAGE, DIVIDER_PIN;
  logic REGULATOR_UNDERVOLTAGE, RX_READY, BUS_DRIVE_LOW, PULLUP_ON, SLOPE_CONTROL_ON;
  logic RX_DATA, RESET_OUT_LOW, RESET_OUT_LOW_OE, ACTIVE_MODE, WATCHDOG_ON;
  logic SWITCH_OUT_ENABLE, TX_STALL;
  int n_errors = 0;
  int n_compared = 0;
  ltdt_ctrl #(
    .DOM_CNT  (DOM),
    .REL_CNT  (REL),
    .HOLD_CNT (HOLD)
  ) i_dut (
    .REF_CLK                 (REF_CLK),
    .RST                     (RST),
    .TX_DATA                 (TX_DATA),
    .TX_DATA_CONNECTED       (TX_DATA_CONNECTED),
    .BUS_LEVEL               (BUS_LEVEL),
    .TRANSCEIVER_ENABLE      (TRANSCEIVER_ENABLE),
    .TIMEOUT_DISABLE         (TIMEOUT_DISABLE),
    .HIGH_SPEED_SLOPE_BYPASS (HIGH_SPEED_SLOPE_BYPASS),
    .SUPPLY_UNDERVOLTAGE     (SUPPLY_UNDERVOLTAGE),
    .REGULATOR_UNDERVOLTAGE  (REGULATOR_UNDERVOLTAGE),
    .DIVIDER_PIN             (DIVIDER_PIN),
    .RX_READY                (RX_READY),
    .BUS_DRIVE_LOW           (BUS_DRIVE_LOW),
    .PULLUP_ON               (PULLUP_ON),
    .SLOPE_CONTROL_ON        (SLOPE_CONTROL_ON),
    .RX_DATA                 (RX_DATA),
    .RESET_OUT_LOW           (RESET_OUT_LOW),
    .RESET_OUT_LOW_OE        (RESET_OUT_LOW_OE),
    .ACTIVE_MODE             (ACTIVE_MODE),
    .WATCHDOG_ON             (WATCHDOG_ON),
    .SWITCH_OUT_ENABLE       (SWITCH_OUT_ENABLE),
    .TX_STALL                (TX_STALL)
  );
  ltdt_host i_host (.clk(REF_CLK), .tx(TX_DATA), .con(TX_DATA_CONNECTED));
  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  // Wire level: pulled low by the driver or by another node
  always @(posedge REF_CLK) BUS_LEVEL <= !(BUS_DRIVE_LOW | bus_low);
  task automatic w(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  task automatic chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_boot();
    w(2);
    chk(ACTIVE_MODE, 1'b1);
    chk(RESET_OUT_LOW_OE, 1'b1);
    chk(RESET_OUT_LOW, 1'b0);
    w(HOLD + 2);
    chk(RESET_OUT_LOW_OE, 1'b0);
    chk(WATCHDOG_ON, 1'b1);
  endtask
  task automatic t_drive();
    i_host.hold(1'b0, 1'b0, 8);
    chk(BUS_DRIVE_LOW, 1'b1);
    chk(RX_DATA, 1'b0);
    i_host.hold(1'b1, 1'b0, 8);
    chk(BUS_DRIVE_LOW, 1'b0);
    i_host.hold(1'b0, 1'b0, 8);
    i_host.hold(1'b0, 1'b1, 8);
    chk(BUS_DRIVE_LOW, 1'b0);
  endtask
  // A short high must not re-arm; a full release must
  task automatic t_timeout();
    i_host.hold(1'b0, 1'b0, DOM + 10);
    chk(BUS_DRIVE_LOW, 1'b0);
    i_host.hold(1'b1, 1'b0, REL - 2);
    i_host.hold(1'b0, 1'b0, 8);
    chk(BUS_DRIVE_LOW, 1'b0);
    i_host.hold(1'b1, 1'b0, REL + 4);
    i_host.hold(1'b0, 1'b0, 8);
    chk(BUS_DRIVE_LOW, 1'b1);
    i_host.hold(1'b1, 1'b0, 8);
  endtask
  task automatic t_modes();
    @(posedge REF_CLK);
    TIMEOUT_DISABLE <= 1'b1;
    HIGH_SPEED_SLOPE_BYPASS <= 1'b1;
    i_host.hold(1'b0, 1'b0, 2 * DOM);
    chk(BUS_DRIVE_LOW, 1'b1);
    chk(SLOPE_CONTROL_ON, 1'b0);
    @(posedge REF_CLK);
    SUPPLY_UNDERVOLTAGE <= 1'b1;
    w(4);
    chk(BUS_DRIVE_LOW, 1'b0);
    chk(SWITCH_OUT_ENABLE, 1'b0);
    @(posedge REF_CLK);
    SUPPLY_UNDERVOLTAGE <= 1'b0;
    HIGH_SPEED_SLOPE_BYPASS <= 1'b0;
    i_host.hold(1'b1, 1'b0, 8);
    chk(SLOPE_CONTROL_ON, 1'b1);
    @(posedge REF_CLK);
    TIMEOUT_DISABLE <= 1'b0;
  endtask
  task automatic t_enable();
    @(posedge REF_CLK);
    bus_low <= 1'b1;
    TRANSCEIVER_ENABLE <= 1'b0;
    w(3);
    chk(PULLUP_ON, 1'b0);
    chk(RX_DATA, 1'b1);
    @(posedge REF_CLK);
    TRANSCEIVER_ENABLE <= 1'b1;
    w(3);
    chk(PULLUP_ON, 1'b1);
    chk(RX_DATA, 1'b0);
    @(posedge REF_CLK);
    bus_low <= 1'b0;
  endtask
  // Strap high during a regulator reset turns the watchdog off
  task automatic t_regu();
    @(posedge REF_CLK);
    DIVIDER_PIN <= 1'b1;
    REGULATOR_UNDERVOLTAGE <= 1'b1;
    w(3);
    chk(RESET_OUT_LOW_OE, 1'b1);
    @(posedge REF_CLK);
    REGULATOR_UNDERVOLTAGE <= 1'b0;
    w(HOLD - 5);
    chk(RESET_OUT_LOW_OE, 1'b1);
    w(10);
    chk(RESET_OUT_LOW_OE, 1'b0);
    chk(WATCHDOG_ON, 1'b0);
    @(posedge REF_CLK);
    DIVIDER_PIN <= 1'b0;
  endtask
  // Drain side stalls while samples keep coming
  task automatic t_stall();
    @(posedge REF_CLK);
    RX_READY <= 1'b0;
    i_host.hold(1'b0, 1'b0, 4);
    i_host.hold(1'b1, 1'b0, 4);
    chk(TX_STALL, 1'b1);
    @(posedge REF_CLK);
    RX_READY <= 1'b1;
    i_host.hold(1'b1, 1'b0, 8);
    chk(TX_STALL, 1'b0);
    chk(BUS_DRIVE_LOW, 1'b0);
  endtask
  initial begin
    {RST, TRANSCEIVER_ENABLE, RX_READY, bus_low, TIMEOUT_DISABLE} = 5'h1C;
    {HIGH_SPEED_SLOPE_BYPASS, SUPPLY_UNDERVOLTAGE, REGULATOR_UNDERVOLTAGE} = 3'h0;
    DIVIDER_PIN = 1'b0;
    // Host idles high through reset; reset spans five edges
    i_host.hold(1'b1, 1'b0, 4);
    @(posedge REF_CLK);
    RST <= 1'b0;
    t_boot();
    t_drive();
    t_timeout();
    t_modes();
    t_enable();
    t_regu();
    t_stall();
    conclude();
  end
  // Cut a hang short well past the expected run length
  initial begin
    repeat (3000) @(posedge REF_CLK);
    n_errors++;
    conclude();
  end
endmodule
bind ltdt_ctrl ltdt_ctrl_props #(
  .DOM_CNT (DOM_CNT)
) u_props (
  .REF_CLK                 (REF_CLK),
  .RST                     (RST),
  .TX_DATA                 (TX_DATA),
  .TX_DATA_CONNECTED       (TX_DATA_CONNECTED),
  .BUS_LEVEL               (BUS_LEVEL),
  .TRANSCEIVER_ENABLE      (TRANSCEIVER_ENABLE),
  .TIMEOUT_DISABLE         (TIMEOUT_DISABLE),
  .HIGH_SPEED_SLOPE_BYPASS (HIGH_SPEED_SLOPE_BYPASS),
  .SUPPLY_UNDERVOLTAGE     (SUPPLY_UNDERVOLTAGE),
  .REGULATOR_UNDERVOLTAGE  (REGULATOR_UNDERVOLTAGE),
  .RX_READY                (RX_READY),
  .BUS_DRIVE_LOW           (BUS_DRIVE_LOW),
  .PULLUP_ON               (PULLUP_ON),
  .SLOPE_CONTROL_ON        (SLOPE_CONTROL_ON),
  .RX_DATA                 (RX_DATA),
  .RESET_OUT_LOW_OE        (RESET_OUT_LOW_OE),
  .SWITCH_OUT_ENABLE       (SWITCH_OUT_ENABLE)
);
`default_nettype wire
